// ### src/bessc_pkg.sv
// Purpose: Shared constants, types and helpers for the converter start-up and setpoint control.
// Assumes: 125 MHz control clock; voltages carried in microvolts.
// Notes:   Cycle counts derive from the printed times and the clock rate.
package bessc_pkg;

  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned SS_US_0         = 500;
  localparam int unsigned SS_US_1         = 770;
  localparam int unsigned SS_US_2         = 1000;
  localparam int unsigned SS_US_3         = 2000;
  localparam int unsigned SS_CYC_0        = SS_US_0 * CLK_MHZ;
  localparam int unsigned SS_CYC_1        = SS_US_1 * CLK_MHZ;
  localparam int unsigned SS_CYC_2        = SS_US_2 * CLK_MHZ;
  localparam int unsigned SS_CYC_3        = SS_US_3 * CLK_MHZ;
  localparam int unsigned SS_CNT_W        = 18;
  localparam int unsigned EN_DELAY_NS     = 1000;
  localparam int unsigned EN_DELAY_CYC    = (EN_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STRAP_SETTLE_NS = 2000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned NONSYNC_CYCLES  = 6;

  localparam logic [1:0]  RANGE_DEFAULT   = 2'h2;
  localparam logic [1:0]  SS_DEFAULT      = 2'h2;
  localparam logic [1:0]  SLEW_DEFAULT    = 2'h2;
  localparam logic [20:0] VOUT_BASE_UV    = 21'h061a80;
  localparam logic [12:0] STEP_UV_FINE    = 13'h04e2;
  localparam logic [12:0] STEP_UV_MID     = 13'h09c4;
  localparam logic [12:0] STEP_UV_COARSE  = 13'h1388;

  // Strap codes: 00 short low, 01 resistor low, 10 resistor high, 11 short high
  localparam logic [7:0]  VSET_DEF_01     = 8'h50;
  localparam logic [7:0]  VSET_DEF_00     = 8'h46;
  localparam logic [7:0]  VSET_DEF_11     = 8'h5f;
  localparam logic [7:0]  VSET_DEF_10     = 8'h24;
  localparam logic [6:0]  ADDR_01         = 7'h44;
  localparam logic [6:0]  ADDR_00         = 7'h45;
  localparam logic [6:0]  ADDR_11         = 7'h46;
  localparam logic [6:0]  ADDR_10         = 7'h47;
  localparam logic [11:0] FREQ_KHZ_01     = 12'h5dc;
  localparam logic [11:0] FREQ_KHZ_00     = 12'h8ca;
  localparam logic [11:0] FREQ_KHZ_11     = 12'h9c4;
  localparam logic [11:0] FREQ_KHZ_10     = 12'hbb8;

  typedef enum logic [2:0] {
    INIT_HOLD  = 3'b000,
    INIT_REF   = 3'b001,
    INIT_STRAP = 3'b011,
    INIT_LOAD  = 3'b010,
    INIT_READY = 3'b110
  } bessc_init_type;

  typedef enum logic [1:0] {
    CONV_OFF   = 2'b00,
    CONV_DELAY = 2'b01,
    CONV_SS    = 2'b11,
    CONV_RUN   = 2'b10
  } bessc_conv_type;

  typedef enum logic [1:0] {
    STRAP_IDLE = 2'b00,
    STRAP_MSB  = 2'b01,
    STRAP_LSB  = 2'b11,
    STRAP_DONE = 2'b10
  } bessc_strap_type;

  function automatic logic [12:0] step_uv(input logic [1:0] range);
    unique case (range)
      2'h0:    step_uv = STEP_UV_FINE;
      2'h1:    step_uv = STEP_UV_MID;
      default: step_uv = STEP_UV_COARSE;
    endcase
  endfunction

  function automatic logic [20:0] target_of(input logic [7:0] code, input logic [1:0] range);
    target_of = VOUT_BASE_UV + 21'(code * step_uv(range));
  endfunction

  function automatic logic [7:0] vset_default(input logic [1:0] strap);
    unique case (strap)
      2'h0: vset_default = VSET_DEF_00;
      2'h1: vset_default = VSET_DEF_01;
      2'h2: vset_default = VSET_DEF_10;
      2'h3: vset_default = VSET_DEF_11;
    endcase
  endfunction

  function automatic logic [6:0] addr_of(input logic [1:0] strap);
    unique case (strap)
      2'h0: addr_of = ADDR_00;
      2'h1: addr_of = ADDR_01;
      2'h2: addr_of = ADDR_10;
      2'h3: addr_of = ADDR_11;
    endcase
  endfunction

  function automatic logic [11:0] freq_of(input logic [1:0] strap);
    unique case (strap)
      2'h0: freq_of = FREQ_KHZ_00;
      2'h1: freq_of = FREQ_KHZ_01;
      2'h2: freq_of = FREQ_KHZ_10;
      2'h3: freq_of = FREQ_KHZ_11;
    endcase
  endfunction

endpackage

// ### src/bessc_strap_decoder.sv
// Purpose: Two-step resistor strap reader driving two probe switches.
// Assumes: Strap pin is asynchronous; settle time exceeds synchroniser latency.
// Notes:   A new start restarts the whole read.
`timescale 1ns/1ps
`default_nettype none
module bessc_strap_decoder #(
  parameter int unsigned SETTLE_CYC = bessc_pkg::STRAP_SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       clk_en,
  input  wire logic       reset_n,
  input  wire logic       start,
  input  wire logic       pin_in,
  output logic            probe_first,
  output logic            probe_second,
  output logic [1:0]      code,
  output logic            done
);
  import bessc_pkg::*;

  logic [2:0]       sync_q;
  logic             level_q;
  bessc_strap_type  state_q;
  logic [15:0]      cnt_q;
  logic             settled;

  assign settled = (cnt_q == 16'(SETTLE_CYC - 1));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else if (clk_en) begin
      sync_q <= {sync_q[1:0], pin_in};
      if (sync_q[1] == sync_q[2]) begin
        level_q <= sync_q[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q      <= STRAP_IDLE;
      cnt_q        <= 16'h0;
      probe_first  <= 1'b0;
      probe_second <= 1'b0;
      code         <= 2'h0;
      done         <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        state_q      <= STRAP_MSB;
        cnt_q        <= 16'h0;
        probe_first  <= 1'b0; // [R16]
        probe_second <= 1'b0;
        done         <= 1'b0;
      end else begin
        unique case (state_q)
          STRAP_IDLE, STRAP_DONE: ;
          STRAP_MSB: begin
            cnt_q <= cnt_q + 16'h1;
            if (settled) begin
              code[1]      <= level_q; // [R16]
              probe_first  <= ~level_q; // [R17]
              probe_second <= level_q; // [R17]
              cnt_q        <= 16'h0;
              state_q      <= STRAP_LSB;
            end
          end
          STRAP_LSB: begin
            cnt_q <= cnt_q + 16'h1;
            if (settled) begin
              code[0]      <= level_q; // [R17]
              probe_first  <= 1'b0;
              probe_second <= 1'b0;
              done         <= 1'b1;
              state_q      <= STRAP_DONE;
            end
          end
        endcase
      end
    end
  end

  property probe_exclusive_p;
    @(posedge clk) disable iff (!reset_n) !(probe_first && probe_second);
  endproperty
  probe_one_a: assert property (probe_exclusive_p) else $error("both probe switches closed"); // [R17]

  msb_open_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == STRAP_MSB |-> !probe_first && !probe_second) else $error("probe closed during msb read"); // [R16]

endmodule
`default_nettype wire

// ### src/bessc_core.sv
// Purpose: Start-up sequencing, enable pin, soft-start and setpoint control of a step-down converter.
// Assumes: Pins pass three-flop synchronisers; register writes come from same-clock logic.
// Notes:   Shadow fields take writes whenever the interface is up; active fields follow them only when allowed.
//
// Functional notes
// [R1] Transient non-synchronous mode keeps the low-side switch off for six cycles.
// [R2] Enable pin held low until defaults loaded and straps sampled.
// [R3] Active fault pulls the enable pin low to stop all stacked converters.
// [R4] Standalone bit stops fault pulldown; initialization pulldown stays regardless.
// [R5] After init without fault the pulldown releases; pin then enables converter.
// [R6] Register interface enabled once initialization ends, independent of enable state.
// [R7] Low enable level means shutdown: switches off, control disabled.
// [R8] Init order: hold enable, start reference, sample straps, load defaults, release.
// [R9] Registers usable with enable high or low; ramp starts after short delay.
// [R10] Soft-start field picks 500 us, 770 us, 1 ms default, or 2 ms.
// [R11] Soft-start codes 00 to 11 map to durations in ascending order.
// [R12] Field writes during soft-start wait; ramp ends at captured setpoint first.
// [R13] Setpoint, slew or soft-start writes while disabled apply at next enable.
// [R14] Start-up ramp allows discontinuous and pulse-frequency operation despite forced PWM.
// [R15] Frequency strap decoded at init to one of four frequencies, then fixed.
// [R16] Strap MSB sampled with both probe switches open.
// [R17] Strap LSB sampled with probe chosen by MSB; high reads one.
// [R18] Range 00 1.25 mV, 01 2.5 mV, 10/11 5 mV steps; default 5 mV.
// [R19] New range applies only when the setpoint is written afterwards.
// [R20] Output target equals 0.4 V plus setpoint code times step size.
// [R21] Voltage strap selects default setpoint code and target address at init.
// [R22] Start-up ramps to strap target before any later programmed value; code ramps straight to any setpoint written while disabled.
`timescale 1ns/1ps
`default_nettype none
module bessc_core #(
  parameter int unsigned SS_CYC_0   = bessc_pkg::SS_CYC_0,
  parameter int unsigned SS_CYC_1   = bessc_pkg::SS_CYC_1,
  parameter int unsigned SS_CYC_2   = bessc_pkg::SS_CYC_2,
  parameter int unsigned SS_CYC_3   = bessc_pkg::SS_CYC_3,
  parameter int unsigned SETTLE_CYC = bessc_pkg::STRAP_SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        clk_en,
  input  wire logic        reset_n,
  input  wire logic        supply_ok_pin,
  input  wire logic        ref_ready_pin,
  input  wire logic        thermal_fault_pin,
  input  wire logic        ovlo_fault_pin,
  input  wire logic        load_release_pin,
  input  wire logic        en_pin_in,
  output logic             en_pin_out,
  output logic             en_pin_oe_n,
  output logic             ref_enable,
  output logic             nvm_load_req,
  input  wire logic        nvm_load_done,
  input  wire logic        voltage_strap_pin,
  output logic             voltage_probe_first,
  output logic             voltage_probe_second,
  input  wire logic        frequency_strap_pin,
  output logic             frequency_probe_first,
  output logic             frequency_probe_second,
  input  wire logic        standalone_bit,
  input  wire logic        fpwm_bit,
  input  wire logic        nonsync_enable,
  input  wire logic        sw_cycle_tick,
  input  wire logic        wr_setpoint,
  input  wire logic [7:0]  wr_setpoint_data,
  input  wire logic        wr_range,
  input  wire logic [1:0]  wr_range_data,
  input  wire logic        wr_softstart,
  input  wire logic [1:0]  wr_softstart_data,
  input  wire logic        wr_slew,
  input  wire logic [1:0]  wr_slew_data,
  output logic             i2c_enable,
  output logic [6:0]       i2c_target_addr,
  output logic [1:0]       freq_code,
  output logic [11:0]      freq_khz,
  output logic [7:0]       setpoint_code_field,
  output logic [1:0]       range_select_field,
  output logic [1:0]       softstart_time_field,
  output logic [1:0]       slew_rate_field,
  output logic [7:0]       active_setpoint,
  output logic [1:0]       active_range,
  output logic [1:0]       active_slew,
  output logic [20:0]      target_uv,
  output logic             converter_on,
  output logic             softstart_active,
  output logic             pfm_allowed,
  output logic             low_side_off
);
  import bessc_pkg::*;

  localparam int unsigned NSYNC = 6;

  // Pin synchronisers and filtered levels
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync3_q;
  logic [NSYNC-1:0] filt_q;
  logic [NSYNC-1:0] filt_d;
  logic             supply_ok;
  logic             ref_ready;
  logic             fault;
  logic             en_level;
  logic             release_rise;

  bessc_init_type   init_q;
  bessc_conv_type   conv_q;
  logic             strap_start_q;
  logic             vs_done;
  logic             fs_done;
  logic [1:0]       vs_code;
  logic [1:0]       fs_code;
  logic [1:0]       range_applied_q;
  logic [1:0]       active_ss_q;
  logic [SS_CNT_W-1:0] cnt_q;
  logic             run_ok;
  logic             init_done;
  logic [2:0]       ns_cnt_q;

  function automatic logic [SS_CNT_W-1:0] ss_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: ss_len = SS_CNT_W'(SS_CYC_0); // [R11]
      2'h1: ss_len = SS_CNT_W'(SS_CYC_1);
      2'h2: ss_len = SS_CNT_W'(SS_CYC_2);
      2'h3: ss_len = SS_CNT_W'(SS_CYC_3);
    endcase
  endfunction

  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < NSYNC; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        filt_d[i] = sync3_q[i];
      end
    end
  end

  assign supply_ok    = filt_q[0];
  assign ref_ready    = filt_q[1];
  assign fault        = filt_q[2] | filt_q[3];
  assign en_level     = filt_q[4];
  assign release_rise = filt_d[5] & ~filt_q[5];
  assign init_done    = (init_q == INIT_READY);
  assign run_ok       = init_done & en_level & ~fault;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end else if (clk_en) begin
      sync1_q <= {load_release_pin, en_pin_in, ovlo_fault_pin, thermal_fault_pin, ref_ready_pin, supply_ok_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  bessc_strap_decoder #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_vstrap (
    .clk          (clk),
    .clk_en       (clk_en),
    .reset_n      (reset_n),
    .start        (strap_start_q),
    .pin_in       (voltage_strap_pin),
    .probe_first  (voltage_probe_first),
    .probe_second (voltage_probe_second),
    .code         (vs_code),
    .done         (vs_done)
  );

  bessc_strap_decoder #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_fstrap (
    .clk          (clk),
    .clk_en       (clk_en),
    .reset_n      (reset_n),
    .start        (strap_start_q),
    .pin_in       (frequency_strap_pin),
    .probe_first  (frequency_probe_first),
    .probe_second (frequency_probe_second),
    .code         (fs_code),
    .done         (fs_done)
  );

  // Power-up sequence; supply loss restarts it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      init_q          <= INIT_HOLD;
      ref_enable      <= 1'b0;
      strap_start_q   <= 1'b0;
      nvm_load_req    <= 1'b0;
      i2c_enable      <= 1'b0;
      i2c_target_addr <= 7'h0;
      freq_code       <= 2'h0;
      freq_khz        <= 12'h0;
    end else if (clk_en) begin
      strap_start_q <= 1'b0;
      if (!supply_ok) begin
        init_q       <= INIT_HOLD;
        ref_enable   <= 1'b0;
        nvm_load_req <= 1'b0;
        i2c_enable   <= 1'b0;
      end else begin
        unique case (init_q)
          INIT_HOLD: begin
            ref_enable <= 1'b1; // [R8]
            init_q     <= INIT_REF;
          end
          INIT_REF: begin
            if (ref_ready) begin
              strap_start_q <= 1'b1; // [R8]
              init_q        <= INIT_STRAP;
            end
          end
          INIT_STRAP: begin
            if (vs_done && fs_done && !strap_start_q) begin
              freq_code       <= fs_code; // [R15]
              freq_khz        <= freq_of(fs_code); // [R15]
              i2c_target_addr <= addr_of(vs_code); // [R21]
              nvm_load_req    <= 1'b1; // [R8]
              init_q          <= INIT_LOAD;
            end
          end
          INIT_LOAD: begin
            if (nvm_load_done) begin
              nvm_load_req <= 1'b0;
              i2c_enable   <= 1'b1; // [R6]
              init_q       <= INIT_READY;
            end
          end
          INIT_READY: ;
          default: init_q <= INIT_HOLD;
        endcase
      end
    end
  end

  // Enable pin: pulled low through init, and on fault unless standalone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_pin_out  <= 1'b0;
      en_pin_oe_n <= 1'b0;
    end else if (clk_en) begin
      en_pin_out  <= 1'b0;
      en_pin_oe_n <= init_done && !(fault && !standalone_bit); // [R2] [R3] [R4] [R5]
    end
  end

  // Shadow fields, writable whenever the interface is up
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      setpoint_code_field  <= 8'h0;
      range_select_field   <= RANGE_DEFAULT;
      softstart_time_field <= SS_DEFAULT;
      slew_rate_field      <= SLEW_DEFAULT;
      range_applied_q      <= RANGE_DEFAULT;
    end else if (clk_en) begin
      if (init_q == INIT_LOAD && nvm_load_done) begin
        setpoint_code_field  <= vset_default(vs_code); // [R21]
        range_select_field   <= RANGE_DEFAULT; // [R18]
        softstart_time_field <= SS_DEFAULT; // [R10]
        slew_rate_field      <= SLEW_DEFAULT;
        range_applied_q      <= RANGE_DEFAULT;
      end else if (i2c_enable) begin
        if (wr_setpoint) begin
          setpoint_code_field <= wr_setpoint_data; // [R9]
          range_applied_q     <= wr_range ? wr_range_data : range_select_field; // [R19]
        end
        if (wr_range) begin
          range_select_field <= wr_range_data;
        end
        if (wr_softstart) begin
          softstart_time_field <= wr_softstart_data;
        end
        if (wr_slew) begin
          slew_rate_field <= wr_slew_data;
        end
      end
    end
  end

  // Converter sequence: off, enable delay, soft-start, regulate
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      conv_q <= CONV_OFF;
      cnt_q  <= '0;
    end else if (clk_en) begin
      if (!run_ok) begin
        conv_q <= CONV_OFF; // [R7]
        cnt_q  <= '0;
      end else begin
        unique case (conv_q)
          CONV_OFF: begin
            conv_q <= CONV_DELAY;
            cnt_q  <= '0;
          end
          CONV_DELAY: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == SS_CNT_W'(EN_DELAY_CYC - 1)) begin
              conv_q <= CONV_SS; // [R9]
              cnt_q  <= '0;
            end
          end
          CONV_SS: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == ss_len(active_ss_q) - 1'b1) begin
              conv_q <= CONV_RUN; // [R10]
              cnt_q  <= '0;
            end
          end
          CONV_RUN: ;
        endcase
      end
    end
  end

  // Active fields: captured at ramp start, frozen during ramp, live while running
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_setpoint <= 8'h0;
      active_range    <= RANGE_DEFAULT;
      active_slew     <= SLEW_DEFAULT;
      active_ss_q     <= SS_DEFAULT;
    end else if (clk_en) begin
      if (conv_q == CONV_OFF || conv_q == CONV_DELAY || conv_q == CONV_RUN) begin
        active_setpoint <= setpoint_code_field; // [R13] [R22]
        active_range    <= range_applied_q; // [R19]
        active_slew     <= slew_rate_field; // [R13]
        active_ss_q     <= softstart_time_field; // [R13]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      target_uv        <= VOUT_BASE_UV;
      converter_on     <= 1'b0;
      softstart_active <= 1'b0;
      pfm_allowed      <= 1'b0;
    end else if (clk_en) begin
      target_uv        <= target_of(active_setpoint, active_range); // [R20] [R18]
      converter_on     <= run_ok && (conv_q == CONV_SS || conv_q == CONV_RUN); // [R7]
      softstart_active <= run_ok && conv_q == CONV_SS; // [R12]
      pfm_allowed      <= (conv_q == CONV_SS) || !fpwm_bit; // [R14]
    end
  end

  // Load-release low-side blanking for a fixed count of switching cycles
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_side_off <= 1'b0;
      ns_cnt_q     <= 3'h0;
    end else if (clk_en) begin
      if (!run_ok) begin
        low_side_off <= 1'b0;
        ns_cnt_q     <= 3'h0;
      end else if (release_rise && nonsync_enable && conv_q == CONV_RUN) begin
        low_side_off <= 1'b1; // [R1]
        ns_cnt_q     <= 3'h0;
      end else if (low_side_off && sw_cycle_tick) begin
        ns_cnt_q <= ns_cnt_q + 3'h1;
        if (ns_cnt_q == 3'(NONSYNC_CYCLES - 1)) begin
          low_side_off <= 1'b0; // [R1]
        end
      end
    end
  end

  init_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    clk_en && !init_done |=> !en_pin_oe_n) else $error("enable released before init done");

  fault_pull_a: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    clk_en && fault && !standalone_bit |=> !en_pin_oe_n) else $error("fault did not pull enable low");

  standalone_free_a: assert property (@(posedge clk) disable iff (!reset_n) // [R4]
    clk_en && init_done && standalone_bit |=> en_pin_oe_n) else $error("standalone pulldown active");

  iface_up_a: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    i2c_enable |-> init_q == INIT_READY) else $error("interface up before init done");

  shutdown_off_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    clk_en && !en_level |=> !converter_on && conv_q == CONV_OFF) else $error("converter on while disabled");

  ramp_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    conv_q == CONV_SS && $past(conv_q) == CONV_SS |-> $stable(active_setpoint) && $stable(active_range))
    else $error("setpoint changed during soft-start");

  target_calc_a: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
    clk_en |=> target_uv == 21'(VOUT_BASE_UV + $past(active_setpoint) * step_uv($past(active_range))))
    else $error("target voltage mismatch");

  ramp_pfm_a: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
    clk_en && conv_q == CONV_SS |=> pfm_allowed) else $error("pfm blocked during ramp");

  nonsync_len_a: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    low_side_off |-> ns_cnt_q < 3'(NONSYNC_CYCLES)) else $error("low-side blanking too long");

  freq_fixed_a: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
    init_done && $past(init_done) |-> $stable(freq_khz)) else $error("frequency changed after init");

endmodule
`default_nettype wire

// ### tb/bessc_en_host.sv
// Purpose: Host side of the shared open-drain enable line.
// Assumes: Line is pulled up to the host level when released.
// Notes:   Any party pulling low wins. Strap code 00 short low, 01 resistor low, 10 resistor high, 11 short high.
`timescale 1ns/1ps
`default_nettype none
module bessc_en_host (
  input  wire logic       host_level,
  input  wire logic       en_pin_oe_n,
  output logic            en_wire,
  input  wire logic [1:0] v_strap,
  input  wire logic [1:0] f_strap,
  input  wire logic       v_probe_first,
  input  wire logic       v_probe_second,
  input  wire logic       f_probe_first,
  input  wire logic       f_probe_second,
  output logic            v_pin,
  output logic            f_pin
);
  assign en_wire = host_level & en_pin_oe_n;
  // Open strap shows its upper bit; only the matching probe overcomes a resistor
  assign v_pin = v_strap[1] ? (v_probe_second ? v_strap[0] : 1'b1) : (v_probe_first & v_strap[0]);
  assign f_pin = f_strap[1] ? (f_probe_second ? f_strap[0] : 1'b1) : (f_probe_first & f_strap[0]);
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: Directed bench for start-up, enable pin and setpoint control.
// Assumes: Shortened soft-start and strap settle counts.
// Notes:   Voltage strap is resistor to high, frequency strap resistor to low.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bessc_pkg::*;
  logic        clk = 0, reset_n = 0, sup = 0, refr = 0, tf = 0, ov = 0, nvd = 0, host = 0, sa = 0;
  logic        fp = 1, nsy = 0, lr = 0, tk = 0, ws = 0, wr = 0, wss = 0, wsl = 0;
  logic        vsp, fsp, vpa, vpb, fpa, fpb, lso;
  logic [1:0]  vsc = 2'h2, fsc = 2'h1;
  logic [7:0]  wd = 8'h00;
  logic        en_w, oe_n, nvq, ie, ss, pfm, con;
  logic [6:0]  addr;
  logic [11:0] fk;
  logic [7:0]  asp;
  logic [1:0]  arg, asl;
  logic [20:0] tuv;
  int          err_total = 0, n_compared = 0, cyc = 0, n = 0;
  bessc_en_host i_host (.host_level(host), .en_pin_oe_n(oe_n), .en_wire(en_w), .v_strap(vsc), .f_strap(fsc),
    .v_probe_first(vpa), .v_probe_second(vpb), .f_probe_first(fpa), .f_probe_second(fpb), .v_pin(vsp), .f_pin(fsp));
  bessc_core #(.SS_CYC_0(20), .SS_CYC_1(30), .SS_CYC_2(40), .SS_CYC_3(50), .SETTLE_CYC(8)) i_dut (
    .clk(clk), .clk_en(1'b1), .reset_n(reset_n), .supply_ok_pin(sup), .ref_ready_pin(refr),
    .thermal_fault_pin(tf), .ovlo_fault_pin(ov), .load_release_pin(lr), .en_pin_in(en_w),
    .en_pin_out(), .en_pin_oe_n(oe_n), .ref_enable(), .nvm_load_req(nvq), .nvm_load_done(nvd),
    .voltage_strap_pin(vsp), .voltage_probe_first(vpa), .voltage_probe_second(vpb),
    .frequency_strap_pin(fsp), .frequency_probe_first(fpa), .frequency_probe_second(fpb),
    .standalone_bit(sa), .fpwm_bit(fp), .nonsync_enable(nsy), .sw_cycle_tick(tk),
    .wr_setpoint(ws), .wr_setpoint_data(wd), .wr_range(wr), .wr_range_data(wd[1:0]),
    .wr_softstart(wss), .wr_softstart_data(wd[1:0]), .wr_slew(wsl), .wr_slew_data(wd[1:0]),
    .i2c_enable(ie), .i2c_target_addr(addr), .freq_code(), .freq_khz(fk), .setpoint_code_field(),
    .range_select_field(), .softstart_time_field(), .slew_rate_field(), .active_setpoint(asp),
    .active_range(arg), .active_slew(asl), .target_uv(tuv), .converter_on(con),
    .softstart_active(ss), .pfm_allowed(pfm), .low_side_off(lso));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Kind 0 setpoint, 1 range, 2 soft-start, 3 slew
  task automatic wr_field(input int k, input logic [7:0] d);
    @(negedge clk);
    {ws, wr, wss, wsl} = 4'h8 >> k;
    wd = d;
    @(negedge clk);
    {ws, wr, wss, wsl} = 4'h0;
  endtask
  task automatic step(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic tick();
    tk = 1;
    step(1);
    tk = 0;
    step(1);
  endtask
  task report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    step(3);
    reset_n = 1;
    sup = 1;
    refr = 1;
    while (!nvq) step(1);
    chk(oe_n, 1'b0);
    chk(ie, 1'b0);
    nvd = 1;
    while (!ie) step(1);
    nvd = 0;
    step(2);
    chk(oe_n, 1'b1);
    chk(addr, ADDR_10);
    chk(fk, FREQ_KHZ_01);
    chk(asp, VSET_DEF_10);
    $display("init test done");
    wr_field(0, 8'h20);
    wr_field(2, 8'h00);
    wr_field(3, 8'h01);
    step(2);
    chk(con, 1'b0);
    chk(ie, 1'b1);
    host = 1;
    while (!ss) step(1);
    chk(pfm, 1'b1);
    chk(asp, 8'h20);
    wr_field(0, 8'h30);
    n = 2;
    chk(asp, 8'h20);
    while (ss) begin
      step(1);
      n++;
    end
    chk(21'(n), 21'h14);
    step(3);
    chk(asp, 8'h30);
    chk(asl, 2'h1);
    chk(tuv, 21'h09c400);
    $display("soft-start test done");
    wr_field(1, 8'h00);
    step(2);
    chk(arg, 2'h2);
    wr_field(0, 8'h30);
    step(2);
    chk(arg, 2'h0);
    chk(tuv, 21'h0704e0);
    $display("range test done");
    chk(pfm, 1'b0);
    fp = 0;
    step(2);
    chk(pfm, 1'b1);
    nsy = 1;
    lr = 1;
    step(6);
    chk(lso, 1'b1);
    repeat (5) tick();
    chk(lso, 1'b1);
    tick();
    chk(lso, 1'b0);
    lr = 0;
    $display("nonsync test done");
    tf = 1;
    step(6);
    chk(oe_n, 1'b0);
    chk(con, 1'b0);
    tf = 0;
    sa = 1;
    step(6);
    ov = 1;
    step(6);
    chk(oe_n, 1'b1);
    chk(con, 1'b0);
    ov = 0;
    $display("fault test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
